//--- tmr_pkg.sv
`default_nettype none
package tmr_pkg;
	// Register byte addresses (one aligned word each)
	localparam logic [7:0] T0_LOW_ADDR   = 8'h00;
	localparam logic [7:0] T0_HIGH_ADDR  = 8'h04;
	localparam logic [7:0] T0_CTRL_ADDR  = 8'h08;
	localparam logic [7:0] T1_LOW_ADDR   = 8'h10;
	localparam logic [7:0] T1_HIGH_ADDR  = 8'h14;
	localparam logic [7:0] T1_CTRL_ADDR  = 8'h18;
	localparam logic [7:0] T2_LOW_ADDR   = 8'h20;
	localparam logic [7:0] T2_HIGH_ADDR  = 8'h24;
	localparam logic [7:0] T2_CTRL_ADDR  = 8'h28;
	localparam logic [7:0] IRQ_FLAG_ADDR = 8'h30;
	localparam logic [7:0] TIMER_STRIDE  = 8'h10;
	// Control register fields
	localparam int MODE_HI_BIT = 7;
	localparam int MODE_LO_BIT = 6;
	localparam int RUN_BIT     = 4;
	localparam int EDGE_BIT    = 3;
	localparam logic [7:0] CTRL_RESET  = 8'h00;
	localparam logic [7:0] CTRL_MASK_EXT = 8'hD8;
	localparam logic [7:0] CTRL_MASK_INT = 8'hD0;
	localparam logic [15:0] COUNT_FULL = 16'hFFFF;
	localparam logic [15:0] PRELOAD_RESET = 16'h0000;
	// Mode field encodings
	typedef enum logic [1:0] {
		MODE_RSVD  = 2'b00,
		MODE_EVENT = 2'b01,
		MODE_TIMER = 2'b10,
		MODE_PULSE = 2'b11
	} mode_t;
	// Clock rates and prescale
	localparam int SYS_CLK_HZ  = 200000000;
	localparam int LF_CLK_HZ   = 32768;
	localparam int T0_PRESCALE = 4;
	localparam logic [1:0] AXI_OKAY   = 2'b00;
	localparam logic [1:0] AXI_SLVERR = 2'b10;
endpackage : tmr_pkg
`default_nettype wire

//--- triple_timer_event_counter.sv
`default_nettype none
// Functional notes
// - Three 16-bit up counters; first two timer/event/pulse, third timer only.
// - Timer0 internal clock is sysclk/4; timer1 internal clock is 32768 Hz.
// - Timer2 counts only the system clock, never a pin.
// - Event mode counts one per selected pin transition.
// - Count preload to FFFF, overflow raises request, reloads, keeps counting.
// - Preload undefined at power-on; software writes it; zero gives longest period.
// - Preload write while stopped also loads the live counter.
// - Preload write while running takes effect at next overflow.
// - Low byte write goes to a holding buffer only.
// - High byte write loads high and transfers buffered low byte.
// - High byte read snapshots live low byte; low read returns snapshot.
// - Control bits 7:6 select the operating mode.
// - Control bit 4 is run control.
// - Control bit 3 selects active polarity for timers 0 and 1.
// - Mode 10 is timer mode, internal clock, request on each overflow.
// - Pin used as I/O: keep timer mode, pin ignored for counting.
// - Edge select 0 counts rising, 1 counts falling transitions.
// - Mode 11 pulse measure: internal clock, waits for first active edge.
// - Pulse end clears run bit; further pin activity ignored until rearmed.
module triple_timer_event_counter #(
	parameter int LF_DIV = tmr_pkg::SYS_CLK_HZ / tmr_pkg::LF_CLK_HZ
) (
	// Clock and reset
	input  wire logic        aclk,
	input  wire logic        aresetn,
	// AXI4-Lite write address
	input  wire logic [7:0]  s_axi_awaddr,
	input  wire logic        s_axi_awvalid,
	output logic             s_axi_awready,
	// AXI4-Lite write data
	input  wire logic [31:0] s_axi_wdata,
	input  wire logic [3:0]  s_axi_wstrb,
	input  wire logic        s_axi_wvalid,
	output logic             s_axi_wready,
	// AXI4-Lite write response
	output logic [1:0]       s_axi_bresp,
	output logic             s_axi_bvalid,
	input  wire logic        s_axi_bready,
	// AXI4-Lite read address
	input  wire logic [7:0]  s_axi_araddr,
	input  wire logic        s_axi_arvalid,
	output logic             s_axi_arready,
	// AXI4-Lite read data
	output logic [31:0]      s_axi_rdata,
	output logic [1:0]       s_axi_rresp,
	output logic             s_axi_rvalid,
	input  wire logic        s_axi_rready,
	// External timer pins
	input  wire logic        timer0_ext_input_pin,
	input  wire logic        timer1_ext_input_pin,
	// Per-timer overflow request flags
	output logic [2:0]       irq_req
);
	localparam int NT = 3;

	// Write channel capture
	logic        aw_held_r;
	logic [7:0]  aw_addr_r;
	logic        w_held_r;
	logic [31:0] w_data_r;
	logic [3:0]  w_strb_r;
	logic        bvalid_r;
	logic [1:0]  bresp_r;
	logic        rvalid_r;
	logic [31:0] rdata_r;
	logic [1:0]  rresp_r;

	logic        wr_go;
	logic        rd_go;
	logic [7:0]  wr_byte;

	assign s_axi_awready = !aw_held_r && !bvalid_r;
	assign s_axi_wready  = !w_held_r && !bvalid_r;
	assign s_axi_arready = !rvalid_r;
	assign s_axi_bvalid  = bvalid_r;
	assign s_axi_bresp   = bresp_r;
	assign s_axi_rvalid  = rvalid_r;
	assign s_axi_rdata   = rdata_r;
	assign s_axi_rresp   = rresp_r;

	assign wr_go   = aw_held_r && w_held_r && !bvalid_r;
	assign rd_go   = s_axi_arvalid && s_axi_arready;
	assign wr_byte = w_data_r[7:0];

	// Register select: timer index and kind (0 low, 1 high, 2 ctrl, 3 none)
	function automatic logic [3:0] decode(input logic [7:0] a);
		logic [1:0] t;
		logic [1:0] k;
		t = 2'd3;
		k = 2'd3;
		if (a[7:6] == 2'b00 && a[1:0] == 2'b00 && a[5:4] != 2'b11 && a[3:2] != 2'b11) begin
			t = a[5:4];
			k = a[3:2];
		end
		return {t, k};
	endfunction : decode

	logic [3:0] wr_dec;
	logic [3:0] rd_dec;
	assign wr_dec = decode(aw_addr_r);
	assign rd_dec = decode(s_axi_araddr);

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			aw_held_r <= 1'b0;
			aw_addr_r <= 8'h00;
		end else if (s_axi_awvalid && s_axi_awready) begin
			aw_held_r <= 1'b1;
			aw_addr_r <= s_axi_awaddr;
		end else if (wr_go) begin
			aw_held_r <= 1'b0;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			w_held_r <= 1'b0;
			w_data_r <= 32'h0000_0000;
			w_strb_r <= 4'h0;
		end else if (s_axi_wvalid && s_axi_wready) begin
			w_held_r <= 1'b1;
			w_data_r <= s_axi_wdata;
			w_strb_r <= s_axi_wstrb;
		end else if (wr_go) begin
			w_held_r <= 1'b0;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			bvalid_r <= 1'b0;
			bresp_r  <= tmp_okay();
		end else if (wr_go) begin
			bvalid_r <= 1'b1;
			bresp_r  <= (wr_dec[1:0] != 2'd3 || aw_addr_r == tmr_pkg::IRQ_FLAG_ADDR)
				? tmr_pkg::AXI_OKAY : tmr_pkg::AXI_SLVERR;
		end else if (s_axi_bready) begin
			bvalid_r <= 1'b0;
		end
	end

	function automatic logic [1:0] tmp_okay();
		return tmr_pkg::AXI_OKAY;
	endfunction : tmp_okay

	// Shared count ticks
	logic [1:0]  pre4_r;
	logic [15:0] lf_cnt_r;
	logic        tick_t0;
	logic        tick_lf;
	assign tick_t0 = (pre4_r == 2'(tmr_pkg::T0_PRESCALE - 1));
	assign tick_lf = (lf_cnt_r == 16'(LF_DIV - 1));

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			pre4_r <= 2'b00;
		end else begin
			pre4_r <= pre4_r + 2'b01;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			lf_cnt_r <= 16'h0000;
		end else if (tick_lf) begin
			lf_cnt_r <= 16'h0000;
		end else begin
			lf_cnt_r <= lf_cnt_r + 16'h0001;
		end
	end

	// Per-timer state
	logic [7:0]  ctrl_r    [NT];
	logic [15:0] count_r   [NT];
	logic [15:0] preload_r [NT];
	logic [7:0]  wbuf_r    [NT];
	logic [7:0]  rbuf_r    [NT];
	logic [NT-1:0] pin_q_r;
	logic [NT-1:0] armed_r;
	logic [NT-1:0] flag_r;
	logic [NT-1:0] pins;
	logic [NT-1:0] int_tick;

	assign pins     = {1'b0, timer1_ext_input_pin, timer0_ext_input_pin};
	assign int_tick = {1'b1, tick_lf, tick_t0};
	assign irq_req  = flag_r;

	logic flag_clr_wr;
	assign flag_clr_wr = wr_go && aw_addr_r == tmr_pkg::IRQ_FLAG_ADDR && w_strb_r[0];

	for (genvar i = 0; i < NT; i++) begin : g_tmr
		logic        sel_w;
		logic        has_pin;
		logic        run;
		logic        edge_sel;
		logic [1:0]  mode;
		logic        rise;
		logic        fall;
		logic        act_edge;
		logic        end_edge;
		logic        inc;
		logic        ovf;
		logic        wr_low;
		logic        wr_high;
		logic        wr_ctrl;
		logic        pw_stop;
		logic [15:0] new_pre;

		assign has_pin  = (i < 2);
		assign sel_w    = wr_go && w_strb_r[0] && wr_dec[3:2] == 2'(i);
		assign wr_low   = sel_w && wr_dec[1:0] == 2'd0;
		assign wr_high  = sel_w && wr_dec[1:0] == 2'd1;
		assign wr_ctrl  = sel_w && wr_dec[1:0] == 2'd2;
		assign mode     = has_pin ? ctrl_r[i][tmr_pkg::MODE_HI_BIT:tmr_pkg::MODE_LO_BIT]
			: tmr_pkg::MODE_TIMER;
		assign run      = ctrl_r[i][tmr_pkg::RUN_BIT];
		assign edge_sel = has_pin && ctrl_r[i][tmr_pkg::EDGE_BIT];
		assign rise     = has_pin && pins[i] && !pin_q_r[i];
		assign fall     = has_pin && !pins[i] && pin_q_r[i];
		// Pin levels are taken as synchronous; the previous sample gives edges.
		// Pulse mode inverts the sense: select low starts on a falling edge and ends when the pin is high again
		assign act_edge = (edge_sel ^ (mode == tmr_pkg::MODE_PULSE)) ? fall : rise;
		assign end_edge = (edge_sel ^ (mode == tmr_pkg::MODE_PULSE)) ? rise : fall;

		// the pin only matters in event and pulse modes
		always_comb begin
			inc     = 1'b0;
			pw_stop = 1'b0;
			unique case (mode)
				tmr_pkg::MODE_EVENT: inc = run && act_edge;
				tmr_pkg::MODE_TIMER: inc = run && int_tick[i];
				tmr_pkg::MODE_PULSE: begin
					inc     = run && armed_r[i] && int_tick[i];
					pw_stop = run && armed_r[i] && end_edge;
				end
				tmr_pkg::MODE_RSVD: inc = 1'b0;
			endcase
		end

		assign ovf     = inc && count_r[i] == tmr_pkg::COUNT_FULL;
		assign new_pre = {wr_byte, wbuf_r[i]};

		always_ff @(posedge aclk) begin
			if (!aresetn) begin
				pin_q_r[i] <= 1'b0;
			end else begin
				pin_q_r[i] <= pins[i];
			end
		end

		always_ff @(posedge aclk) begin
			if (!aresetn) begin
				ctrl_r[i] <= tmr_pkg::CTRL_RESET;
			end else if (wr_ctrl) begin
				ctrl_r[i] <= wr_byte & (has_pin ? tmr_pkg::CTRL_MASK_EXT : tmr_pkg::CTRL_MASK_INT);
			end else if (pw_stop) begin
				ctrl_r[i][tmr_pkg::RUN_BIT] <= 1'b0;
			end
		end

		// Pulse mode arms on the first active edge after run is set
		always_ff @(posedge aclk) begin
			if (!aresetn) begin
				armed_r[i] <= 1'b0;
			end else if (!run || mode != tmr_pkg::MODE_PULSE || pw_stop) begin
				armed_r[i] <= 1'b0;
			end else if (act_edge) begin
				armed_r[i] <= 1'b1;
			end
		end

		always_ff @(posedge aclk) begin
			if (!aresetn) begin
				wbuf_r[i] <= 8'h00;
			end else if (wr_low) begin
				wbuf_r[i] <= wr_byte;
			end
		end

		// Reset value only gives simulation a defined start; software must load it
		always_ff @(posedge aclk) begin
			if (!aresetn) begin
				preload_r[i] <= tmr_pkg::PRELOAD_RESET;
			end else if (wr_high) begin
				preload_r[i] <= new_pre;
			end
		end

		always_ff @(posedge aclk) begin
			if (!aresetn) begin
				count_r[i] <= tmr_pkg::PRELOAD_RESET;
			end else if (wr_high && !run) begin
				count_r[i] <= new_pre;
			end else if (ovf) begin
				count_r[i] <= preload_r[i];
			end else if (inc) begin
				count_r[i] <= count_r[i] + 16'h0001;
			end
		end

		always_ff @(posedge aclk) begin
			if (!aresetn) begin
				rbuf_r[i] <= 8'h00;
			end else if (rd_go && rd_dec[3:2] == 2'(i) && rd_dec[1:0] == 2'd1) begin
				rbuf_r[i] <= count_r[i][7:0];
			end
		end

		// Set wins over a clear in the same cycle
		always_ff @(posedge aclk) begin
			if (!aresetn) begin
				flag_r[i] <= 1'b0;
			end else if (ovf) begin
				flag_r[i] <= 1'b1;
			end else if (flag_clr_wr && wr_byte[i]) begin
				flag_r[i] <= 1'b0;
			end
		end
	end

	// Read path
	logic [31:0] rd_val;
	always_comb begin
		rd_val = 32'h0000_0000;
		unique case (rd_dec[1:0])
			2'd0: rd_val = {24'h000000, rbuf_r[rd_dec[3:2]]};
			2'd1: rd_val = {24'h000000, count_r[rd_dec[3:2]][15:8]};
			2'd2: rd_val = {24'h000000, ctrl_r[rd_dec[3:2]]};
			2'd3: rd_val = (s_axi_araddr == tmr_pkg::IRQ_FLAG_ADDR) ? {29'h0, flag_r} : 32'h0000_0000;
		endcase
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			rvalid_r <= 1'b0;
			rdata_r  <= 32'h0000_0000;
			rresp_r  <= tmr_pkg::AXI_OKAY;
		end else if (rd_go) begin
			rvalid_r <= 1'b1;
			rdata_r  <= rd_val;
			rresp_r  <= (rd_dec[1:0] != 2'd3 || s_axi_araddr == tmr_pkg::IRQ_FLAG_ADDR)
				? tmr_pkg::AXI_OKAY : tmr_pkg::AXI_SLVERR;
		end else if (s_axi_rready) begin
			rvalid_r <= 1'b0;
		end
	end
endmodule : triple_timer_event_counter
`default_nettype wire

//--- tmr_properties.sv
`default_nettype none
module tmr_properties (
	// Clock and reset
	input wire logic        aclk,
	input wire logic        aresetn,
	// Bus handshakes
	input wire logic        s_axi_awvalid,
	input wire logic        s_axi_awready,
	input wire logic        s_axi_wvalid,
	input wire logic        s_axi_wready,
	input wire logic        s_axi_bvalid,
	input wire logic        s_axi_bready,
	input wire logic        s_axi_arvalid,
	input wire logic        s_axi_arready,
	input wire logic [31:0] s_axi_rdata,
	input wire logic        s_axi_rvalid,
	input wire logic        s_axi_rready,
	// Flags
	input wire logic [2:0]  irq_req
);
	default clocking @(posedge aclk); endclocking
	default disable iff (!aresetn);
	sequence wr_taken_s;
		s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
	endsequence
	sequence wr_answer_s;
		!s_axi_bvalid ##1 s_axi_bvalid;
	endsequence
	write_answer_a: assert property (wr_taken_s |=> wr_answer_s) else $error("late write response");
	bresp_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid) else $error("bvalid dropped");
	write_block_a: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready) else $error("write not held off");
	read_answer_a: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid) else $error("late read data");
	rdata_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
		else $error("read data moved");
	byte_lane_a: assert property (s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h000000) else $error("upper read bits");
	read_block_a: assert property (s_axi_rvalid |-> !s_axi_arready) else $error("read not held off");
	flag_sticky_a: assert property (($past(irq_req) & ~irq_req) != 3'h0 |-> $rose(s_axi_bvalid))
		else $error("flag fell without clear");
endmodule : tmr_properties
bind triple_timer_event_counter tmr_properties chk (.*);
`default_nettype wire

//--- event_source.sv
`default_nettype none
module event_source (
	// Clock
	input wire logic aclk,
	// Timer pins
	output logic     timer0_ext_input_pin,
	output logic     timer1_ext_input_pin
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [1:0] pin_r = 2'b00;
	assign timer0_ext_input_pin = pin_r[0];
	assign timer1_ext_input_pin = pin_r[1];
	// Pins rest low between pulses so that no stray edge is seen
	task automatic pulse(input int ch, input int hi, input int lo);
		@(posedge aclk) pin_r[ch] <= 1'b1;
		repeat (hi) @(posedge aclk);
		pin_r[ch] <= 1'b0;
		repeat (lo) @(posedge aclk);
	endtask : pulse
endmodule : event_source
`default_nettype wire

//--- triple_timer_event_counter_tb.sv
`default_nettype none
module triple_timer_event_counter_tb;
	timeunit 1ns;
	timeprecision 1ps;
	logic        aclk, rvalid, bvalid, awready, wready, arready, pin0, pin1;
	logic        aresetn = 1'b0, awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
	logic [7:0]  awaddr = 8'h00, araddr = 8'h00, v;
	logic [31:0] wdata = 32'h0, rdata;
	logic [1:0]  bresp, rresp;
	logic [2:0]  irq_req;
	int          fail_count = 0, checks = 0, cyc = 0;
	triple_timer_event_counter #(.LF_DIV(4)) dut (.aclk(aclk), .aresetn(aresetn),
		.s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
		.s_axi_wstrb(4'h1), .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
		.s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
		.s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
		.s_axi_rready(rready), .timer0_ext_input_pin(pin0), .timer1_ext_input_pin(pin1), .irq_req(irq_req));
	event_source src (.aclk(aclk), .timer0_ext_input_pin(pin0), .timer1_ext_input_pin(pin1));
	initial begin
		aclk = 1'b0;
		forever #2.5 aclk = ~aclk;
	end
	task automatic report_and_stop();
		$display("checks %0d mismatches %0d", checks, fail_count);
		if (fail_count == 0 && checks > 0) begin
			$display("Result: passed");
		end else begin
			$display("Result: failed");
		end
		$finish;
	endtask : report_and_stop
	always @(posedge aclk) begin
		cyc <= cyc + 1;
		if (cyc == 5000) begin
			fail_count++;
			report_and_stop();
		end
	end
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp, input string what);
		checks++;
		if (seen !== exp) begin
			fail_count++;
			$display("BAD %s expected %h seen %h", what, exp, seen);
		end
	endtask : chk
	// Handshakes are judged at the falling edge, where the outputs of the last rising edge have settled
	task automatic axw(input logic [7:0] a, input logic [7:0] d, input logic [1:0] er = tmr_pkg::AXI_OKAY);
		logic aw, w, b;
		aw = 1'b1;
		w = 1'b1;
		b = 1'b1;
		@(posedge aclk);
		awaddr <= a;
		wdata <= {24'h000000, d};
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		while (b) begin
			@(negedge aclk);
			aw = aw && !awready;
			w = w && !wready;
			b = !bvalid;
			if (bvalid) chk(bresp, er, "bresp");
			@(posedge aclk);
			awvalid <= aw;
			wvalid <= w;
			bready <= b;
		end
	endtask : axw
	task automatic axr(input logic [7:0] a, input logic [1:0] er = tmr_pkg::AXI_OKAY);
		logic ar, r;
		ar = 1'b1;
		r = 1'b1;
		@(posedge aclk);
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		while (r) begin
			@(negedge aclk);
			ar = ar && !arready;
			r = !rvalid;
			if (rvalid) chk(rresp, er, "rresp");
			v = rdata[7:0];
			@(posedge aclk);
			arvalid <= ar;
			rready <= r;
		end
	endtask : axr
	task automatic t_regs();
		axr(tmr_pkg::T0_CTRL_ADDR);
		chk(v, tmr_pkg::CTRL_RESET, "ctrl reset");
		axw(tmr_pkg::T1_CTRL_ADDR, 8'hCB);
		axr(tmr_pkg::T1_CTRL_ADDR);
		chk(v, 8'hC8, "ctrl1 fields");
		axw(tmr_pkg::T2_CTRL_ADDR, 8'hCB);
		axr(tmr_pkg::T2_CTRL_ADDR);
		chk(v, 8'hC0, "ctrl2 fields");
		axw(8'h3C, 8'h00, tmr_pkg::AXI_SLVERR);
		axr(8'h3C, tmr_pkg::AXI_SLVERR);
		chk(v, 8'h00, "unmapped");
	endtask : t_regs
	task automatic t_buf();
		axw(tmr_pkg::T2_LOW_ADDR, 8'h34);
		axr(tmr_pkg::T2_HIGH_ADDR);
		axr(tmr_pkg::T2_LOW_ADDR);
		chk(v, 8'h00, "low held");
		axw(tmr_pkg::T2_HIGH_ADDR, 8'h12);
		axr(tmr_pkg::T2_HIGH_ADDR);
		chk(v, 8'h12, "high direct");
		axw(tmr_pkg::T2_LOW_ADDR, 8'h56);
		axw(tmr_pkg::T2_HIGH_ADDR, 8'h78);
		axr(tmr_pkg::T2_LOW_ADDR);
		chk(v, 8'h34, "snapshot");
		axr(tmr_pkg::T2_HIGH_ADDR);
		chk(v, 8'h78, "stopped load");
		axr(tmr_pkg::T2_LOW_ADDR);
		chk(v, 8'h56, "low moved");
	endtask : t_buf
	task automatic t_event();
		axw(tmr_pkg::T0_LOW_ADDR, 8'h00);
		axw(tmr_pkg::T0_HIGH_ADDR, 8'h00);
		axw(tmr_pkg::T0_CTRL_ADDR, 8'h50);
		repeat (5) src.pulse(0, 3, 3);
		axw(tmr_pkg::T0_CTRL_ADDR, 8'h40);
		axr(tmr_pkg::T0_HIGH_ADDR);
		axr(tmr_pkg::T0_LOW_ADDR);
		chk(v, 8'h05, "rising count");
		axw(tmr_pkg::T0_CTRL_ADDR, 8'h58);
		repeat (3) src.pulse(0, 3, 3);
		axw(tmr_pkg::T0_CTRL_ADDR, 8'h48);
		axr(tmr_pkg::T0_HIGH_ADDR);
		axr(tmr_pkg::T0_LOW_ADDR);
		chk(v, 8'h08, "falling count");
	endtask : t_event
	task automatic t_pulse();
		logic [7:0] w;
		axw(tmr_pkg::T1_LOW_ADDR, 8'h00);
		axw(tmr_pkg::T1_HIGH_ADDR, 8'h00);
		axw(tmr_pkg::T1_CTRL_ADDR, 8'hD8);
		repeat (20) @(posedge aclk);
		src.pulse(1, 40, 8);
		axr(tmr_pkg::T1_CTRL_ADDR);
		chk(v, 8'hC8, "run cleared");
		axr(tmr_pkg::T1_HIGH_ADDR);
		axr(tmr_pkg::T1_LOW_ADDR);
		w = v;
		chk(w inside {[8'h09:8'h0B]}, 1'b1, "width");
		src.pulse(1, 40, 8);
		axr(tmr_pkg::T1_HIGH_ADDR);
		axr(tmr_pkg::T1_LOW_ADDR);
		chk(v, w, "no rearm");
	endtask : t_pulse
	task automatic t_ovf();
		axw(tmr_pkg::T2_LOW_ADDR, 8'hE0);
		axw(tmr_pkg::T2_HIGH_ADDR, 8'hFF);
		axw(tmr_pkg::T2_CTRL_ADDR, 8'h90);
		axw(tmr_pkg::T2_LOW_ADDR, 8'h00);
		axw(tmr_pkg::T2_HIGH_ADDR, 8'h80);
		axr(tmr_pkg::T2_HIGH_ADDR);
		chk(v, 8'hFF, "no early load");
		repeat (60) if (irq_req[2] !== 1'b1) @(posedge aclk);
		axw(tmr_pkg::T2_CTRL_ADDR, 8'h80);
		axr(tmr_pkg::T2_HIGH_ADDR);
		chk(v, 8'h80, "reload");
		axr(tmr_pkg::IRQ_FLAG_ADDR);
		chk(v, 8'h04, "flag set");
		axw(tmr_pkg::IRQ_FLAG_ADDR, 8'h04);
		axr(tmr_pkg::IRQ_FLAG_ADDR);
		chk(v, 8'h00, "flag clear");
	endtask : t_ovf
	initial begin
		repeat (4) @(posedge aclk);
		aresetn <= 1'b1;
		t_regs();
		t_buf();
		t_event();
		t_pulse();
		t_ovf();
		report_and_stop();
	end
endmodule : triple_timer_event_counter_tb
`default_nettype wire
